// *** core/chs_params.svh ***
// Constants for the charger host status interface
// Operation
// - Status pin low charging, high done, blink suspended
// - Pulse interrupt 256 us on listed events
// - Fault raises interrupt, held until register read
// - No new fault interrupts until read and clear
// - First read latched faults, second read live
// - Thermal regulation cuts current, halves timer, flags
// - Thermal shutdown stops converter, fault code 10
// - Input over-voltage stops switching, fault code 01
// - System rail over-voltage stops the converter
// - Battery over-voltage disables charge, sets bit five
// - Battery below 2 V limits current
// - Over-current latches path switch off until insertion
// - Answer I2C address 6BH at 400 kbit
// - Bytes are eight bits, MSB first, acknowledged
// - Receiver pulls data low on ninth clock
// - Address is seven bits plus direction bit
// - Undefined register address gets NACK, back idle
// - Burst access 00 to 08, fault single
// - Reset starts default mode, mode bit high
// - Any write enters host mode
// - Phase field encodes none, pre, fast, done
// - Registers 00-07 writable, 08-0A read-only
// - Watchdog restart bit clears itself
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH
`define CHS_I2C_ADDR 7'h6B
`define CHS_REG_LAST_RW 8'h07
`define CHS_REG_STATUS 8'h08
`define CHS_REG_FAULT 8'h09
`define CHS_REG_ID 8'h0A
`define CHS_IDX_SRC 3'h0
`define CHS_IDX_PWR 3'h1
`define CHS_IDX_TERM 3'h5
`define CHS_RST_REG0 8'h30
`define CHS_RST_REG1 8'h1B
`define CHS_RST_REG2 8'h60
`define CHS_RST_REG3 8'h11
`define CHS_RST_REG4 8'hB2
`define CHS_RST_REG5 8'h9A
`define CHS_RST_REG6 8'h03
`define CHS_RST_REG7 8'h4B
`define CHS_ID_VALUE 8'h5A
`define CHS_HIZ_BIT 7
`define CHS_REGRST_BIT 7
`define CHS_WDRST_BIT 6
`define CHS_CHGCFG_LSB 4
`define CHS_TERMEN_BIT 7
`define CHS_WDPER_LSB 4
`define CHS_PHASE_LSB 4
`define CHS_THERMREG_BIT 1
`define CHS_CF_INOV 2'h1
`define CHS_CF_THERM 2'h2
`define CHS_CF_TIMER 2'h3
`define CHS_PH_PRE 2'h1
`define CHS_PH_FAST 2'h2
`define CHS_PH_DONE 2'h3
`define CHS_CHG_ON 2'h1
`define CHS_WD_OFF 2'h0
`define CHS_CLK_PERIOD_NS 4
`define CHS_INT_PULSE_NS 256000
`define CHS_INT_PULSE_CYC ((`CHS_INT_PULSE_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_BLINK_HALF_NS 500000000
`define CHS_BLINK_HALF_CYC (`CHS_BLINK_HALF_NS / `CHS_CLK_PERIOD_NS)
`define CHS_WD_TICK_NS 1000000000
`define CHS_WD_TICK_CYC (`CHS_WD_TICK_NS / `CHS_CLK_PERIOD_NS)
`define CHS_WD_BASE_S 40
`endif

// *** core/chs_pkg.sv ***
// Types of the charger host status interface
package chs_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_RX = 7'h04,
    ST_ACK = 7'h08,
    ST_TX = 7'h10,
    ST_MACK = 7'h20,
    ST_WAIT = 7'h40
  } chs_state_t;
  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    chs_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh, ptr;
    logic got_ptr, rw, mack, sda_oe, zero_drv;
    logic [7:0][7:0] cfg;
    logic host_mode;
    logic [27:0] wd_tick;
    logic [7:0] wd_sec;
    logic [6:0] fl, live_prev;
    logic lock, int_tog;
    logic [1:0] phase_prev;
    logic battery_path_switch_off, supply_prev, stop_conv, chg_en, ilim100;
    logic therm_reduce, term_dis, half_rate, chg_lvl, sus_lvl;
  } chs_core_t;
  typedef struct packed {
    logic int_s1, int_s2, int_s3, chg_s1, chg_s2, sus_s1, sus_s2;
    logic [15:0] int_cnt;
    logic int_b;
    logic [26:0] blink_cnt;
    logic blink, stat_oe, stat_lo;
  } chs_osc_t;
endpackage

// *** core/chs_top.sv ***
// Charger host status interface: I2C slave, fault latch, status and interrupt pins
`timescale 1ns/1ns
`include "chs_params.svh"
module chs_top #(
  parameter int unsigned INT_PULSE_CYC = `CHS_INT_PULSE_CYC,
  parameter int unsigned BLINK_HALF_CYC = `CHS_BLINK_HALF_CYC,
  parameter int unsigned WD_TICK_CYC = `CHS_WD_TICK_CYC,
  parameter int unsigned WD_BASE_S = `CHS_WD_BASE_S
) (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic osc_clk_in,
  // I2C pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Status pin (open drain) and interrupt pulse
  output logic stat_out,
  output logic stat_oe_out,
  output logic host_int_b_out,
  // Charger events and levels, on clk_in
  input wire logic [1:0] charge_phase_in,
  input wire logic charge_suspend_in,
  input wire logic src_identified_in,
  input wire logic good_source_in,
  input wire logic input_removed_in,
  input wire logic thermal_reg_in,
  input wire logic thermal_shutdown_in,
  input wire logic input_overvoltage_fault_in,
  input wire logic system_rail_overvoltage_in,
  input wire logic battery_overvoltage_fault_in,
  input wire logic safety_timer_fault_in,
  input wire logic [2:0] ntc_fault_in,
  input wire logic battery_low_in,
  input wire logic system_overcurrent_in,
  input wire logic supply_present_in,
  // Control outputs to the power stage
  output logic stop_converter_out,
  output logic charge_enable_out,
  output logic current_limit_100ma_out,
  output logic thermal_reduce_out,
  output logic termination_disable_out,
  output logic timer_half_rate_out,
  output logic battery_path_switch_off_out,
  output logic en_hiz_out,
  output logic host_mode_out
);
  // Fixed-width counters cannot hold larger values; refused at elaboration
  if (INT_PULSE_CYC < 1 || INT_PULSE_CYC > 65535) $error("INT_PULSE_CYC out of range");
  if (BLINK_HALF_CYC < 1 || BLINK_HALF_CYC > 134217727) $error("BLINK_HALF_CYC out of range");
  if (WD_TICK_CYC < 1 || WD_TICK_CYC > 268435455) $error("WD_TICK_CYC out of range");
  if (WD_BASE_S < 1 || WD_BASE_S > 63) $error("WD_BASE_S out of range");
  localparam logic [7:0][7:0] CFG_RST = {`CHS_RST_REG7, `CHS_RST_REG6, `CHS_RST_REG5,
    `CHS_RST_REG4, `CHS_RST_REG3, `CHS_RST_REG2, `CHS_RST_REG1, `CHS_RST_REG0};
  function automatic chs_pkg::chs_core_t core_reset();
    chs_pkg::chs_core_t r;
    r = '0;
    {r.scl_s1, r.scl_s2, r.scl_s3, r.sda_s1, r.sda_s2, r.sda_s3} = 6'h3F;
    r.st = chs_pkg::ST_IDLE;
    r.cfg = CFG_RST;
    r.chg_en = 1'h1;
    return r;
  endfunction
  localparam chs_pkg::chs_core_t CORE_RST = core_reset();
  // Register read mux, used on the first and on each following read byte
  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0][7:0] cfg,
                                          input logic [7:0] status, input logic [7:0] fault);
    logic [7:0] v;
    v = 8'h00;
    if (p <= `CHS_REG_LAST_RW) begin
      v = cfg[p[2:0]];
    end else if (p == `CHS_REG_STATUS) begin
      v = status;
    end else if (p == `CHS_REG_FAULT) begin
      v = fault;
    end else if (p == `CHS_REG_ID) begin
      v = `CHS_ID_VALUE;
    end
    return v;
  endfunction
  // Bursts walk 00..08; fault and id registers never advance the pointer
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    return (p < `CHS_REG_STATUS) ? p + 8'h01 : p;
  endfunction

  function automatic logic [7:0] wd_limit(input logic [1:0] f);
    logic [7:0] b;
    b = 8'(WD_BASE_S);
    case (f)
      2'h1: wd_limit = b;
      2'h2: wd_limit = b << 1;
      default: wd_limit = b << 2;
    endcase
  endfunction
  chs_pkg::chs_core_t c, next_c;
  chs_pkg::chs_osc_t o, next_o;
  logic scl_rise, scl_fall, start_det, stop_det, fault_rd, wr_any, ev, new_fault;
  logic [1:0] cf_code;
  logic [6:0] live;
  logic [7:0] status_byte, fault_byte, rd_byte;

  // Edges taken from the second and third sync stages only
  assign scl_rise = c.scl_s2 & ~c.scl_s3;
  assign scl_fall = ~c.scl_s2 & c.scl_s3;
  assign start_det = c.scl_s2 & c.scl_s3 & c.sda_s3 & ~c.sda_s2;
  assign stop_det = c.scl_s2 & c.scl_s3 & ~c.sda_s3 & c.sda_s2;

  // Live fault view: input over-voltage outranks thermal, then timer
  assign cf_code = input_overvoltage_fault_in ? `CHS_CF_INOV :
                   thermal_shutdown_in ? `CHS_CF_THERM :
                   safety_timer_fault_in ? `CHS_CF_TIMER : 2'h0;
  assign live = {1'h0, cf_code[1] | battery_overvoltage_fault_in, cf_code[0], 1'h0,
                 ntc_fault_in};
  assign status_byte = {2'h0, charge_phase_in, 2'h0, thermal_reg_in, 1'h0};
  assign fault_byte = {~c.host_mode, c.fl};
  assign rd_byte = reg_read(c.ptr, c.cfg, status_byte, fault_byte);
  assign new_fault = |(live & ~c.live_prev);

  // Core next-state: I2C slave, registers, watchdog, fault latch, protections
  always_comb begin
    next_c = c;
    fault_rd = 1'h0;
    wr_any = 1'h0;
    ev = 1'h0;
    next_c.scl_s1 = scl_in;
    next_c.scl_s2 = c.scl_s1;
    next_c.scl_s3 = c.scl_s2;
    next_c.sda_s1 = sda_in;
    next_c.sda_s2 = c.sda_s1;
    next_c.sda_s3 = c.sda_s2;
    if (start_det) begin
      next_c.st = chs_pkg::ST_ADDR;
      next_c.cnt = 4'h0;
      next_c.got_ptr = 1'h0;
      next_c.sda_oe = 1'h0;
    end else if (stop_det) begin
      next_c.st = chs_pkg::ST_IDLE;
      next_c.sda_oe = 1'h0;
    end else if (scl_rise) begin
      case (c.st)
        chs_pkg::ST_ADDR, chs_pkg::ST_RX: begin
          next_c.sh = {c.sh[6:0], c.sda_s2};
          next_c.cnt = c.cnt + 4'h1;
        end
        chs_pkg::ST_TX: next_c.cnt = c.cnt + 4'h1;
        chs_pkg::ST_MACK: next_c.mack = ~c.sda_s2;
        default: next_c.cnt = c.cnt;
      endcase
    end else if (scl_fall) begin
      case (c.st)
        chs_pkg::ST_ADDR: begin
          if (c.cnt == 4'h8) begin
            if (c.sh[7:1] == `CHS_I2C_ADDR) begin
              next_c.st = chs_pkg::ST_ACK;
              next_c.rw = c.sh[0];
              next_c.sda_oe = 1'h1;
            end else begin
              next_c.st = chs_pkg::ST_WAIT;
            end
          end
        end
        chs_pkg::ST_RX: begin
          if (c.cnt == 4'h8 && !c.got_ptr) begin
            if (c.sh <= `CHS_REG_ID) begin
              next_c.ptr = c.sh;
              next_c.got_ptr = 1'h1;
              next_c.st = chs_pkg::ST_ACK;
              next_c.sda_oe = 1'h1;
            end else begin
              next_c.st = chs_pkg::ST_WAIT;
            end
          end else if (c.cnt == 4'h8) begin
            wr_any = 1'h1;
            if (c.ptr <= `CHS_REG_LAST_RW) begin
              next_c.cfg[c.ptr[2:0]] = c.sh;
            end
            next_c.ptr = next_ptr(c.ptr);
            next_c.st = chs_pkg::ST_ACK;
            next_c.sda_oe = 1'h1;
          end
        end
        chs_pkg::ST_ACK: begin
          next_c.cnt = 4'h0;
          if (c.rw) begin
            next_c.sh = rd_byte;
            next_c.sda_oe = ~rd_byte[7];
            next_c.st = chs_pkg::ST_TX;
          end else begin
            next_c.sda_oe = 1'h0;
            next_c.st = chs_pkg::ST_RX;
          end
        end
        chs_pkg::ST_TX: begin
          if (c.cnt == 4'h8) begin
            next_c.sda_oe = 1'h0;
            next_c.st = chs_pkg::ST_MACK;
            fault_rd = (c.ptr == `CHS_REG_FAULT);
            next_c.ptr = next_ptr(c.ptr);
          end else begin
            next_c.sh = {c.sh[6:0], 1'h0};
            next_c.sda_oe = ~c.sh[6];
          end
        end
        chs_pkg::ST_MACK: begin
          if (c.mack) begin
            next_c.sh = rd_byte;
            next_c.sda_oe = ~rd_byte[7];
            next_c.cnt = 4'h0;
            next_c.st = chs_pkg::ST_TX;
          end else begin
            next_c.st = chs_pkg::ST_WAIT;
          end
        end
        default: next_c.st = c.st;
      endcase
    end
    // Watchdog: counts only in host mode with a nonzero period
    if (c.host_mode && c.cfg[`CHS_IDX_TERM][`CHS_WDPER_LSB +: 2] != `CHS_WD_OFF) begin
      next_c.wd_tick = c.wd_tick + 28'h1;
      if (c.wd_tick == 28'(WD_TICK_CYC - 1)) begin
        next_c.wd_tick = 28'h0;
        next_c.wd_sec = c.wd_sec + 8'h01;
        if (c.wd_sec + 8'h01 >= wd_limit(c.cfg[`CHS_IDX_TERM][`CHS_WDPER_LSB +: 2])) begin
          next_c.host_mode = 1'h0;
          next_c.cfg = CFG_RST;
        end
      end
    end
    // Reset and restart bits act the cycle after the write, then fall back to 0
    if (c.cfg[`CHS_IDX_PWR][`CHS_REGRST_BIT]) begin
      next_c.cfg = CFG_RST;
    end
    if (c.cfg[`CHS_IDX_PWR][`CHS_WDRST_BIT]) begin
      next_c.wd_tick = 28'h0;
      next_c.wd_sec = 8'h00;
      next_c.cfg[`CHS_IDX_PWR][`CHS_WDRST_BIT] = 1'h0;
    end
    // A write keeps host mode over a watchdog expiry in the same cycle; the register reload still wins
    if (wr_any) begin
      next_c.host_mode = 1'h1;
      if (!c.host_mode) begin
        next_c.wd_tick = 28'h0;
        next_c.wd_sec = 8'h00;
      end
    end
    // Fault latch: live faults are OR-ed in even on the reload cycle
    next_c.fl = fault_rd ? live : (c.fl | live);
    next_c.live_prev = live;
    if (fault_rd && live == 7'h00) begin
      next_c.lock = 1'h0;
    end
    if (new_fault && !c.lock) begin
      next_c.lock = 1'h1;
      ev = 1'h1;
    end
    // Interrupt sources; the pulse itself is timed in the oscillator domain
    next_c.phase_prev = charge_phase_in;
    if (src_identified_in || good_source_in || input_removed_in || ev ||
        (charge_phase_in == `CHS_PH_DONE && c.phase_prev != `CHS_PH_DONE)) begin
      next_c.int_tog = ~c.int_tog;
    end
    // Protections and regulation outputs
    next_c.stop_conv = thermal_shutdown_in | input_overvoltage_fault_in |
                       system_rail_overvoltage_in;
    next_c.chg_en = (c.cfg[`CHS_IDX_PWR][`CHS_CHGCFG_LSB +: 2] == `CHS_CHG_ON) &
                    ~battery_overvoltage_fault_in;
    next_c.ilim100 = battery_low_in;
    next_c.therm_reduce = thermal_reg_in;
    next_c.term_dis = thermal_reg_in | ~c.cfg[`CHS_IDX_TERM][`CHS_TERMEN_BIT];
    next_c.half_rate = thermal_reg_in;
    next_c.supply_prev = supply_present_in;
    if (system_overcurrent_in) begin
      next_c.battery_path_switch_off = 1'h1;
    end else if (supply_present_in && !c.supply_prev) begin
      next_c.battery_path_switch_off = 1'h0;
    end
    next_c.chg_lvl = (charge_phase_in == `CHS_PH_PRE) || (charge_phase_in == `CHS_PH_FAST);
    next_c.sus_lvl = charge_suspend_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      c <= CORE_RST;
    end else begin
      c <= next_c;
    end
  end

  // Oscillator domain: interrupt pulse and status blink, free of SCL
  always_comb begin
    next_o = o;
    next_o.int_s1 = c.int_tog;
    next_o.int_s2 = o.int_s1;
    next_o.int_s3 = o.int_s2;
    next_o.chg_s1 = c.chg_lvl;
    next_o.chg_s2 = o.chg_s1;
    next_o.sus_s1 = c.sus_lvl;
    next_o.sus_s2 = o.sus_s1;
    if (o.int_s2 ^ o.int_s3) begin
      next_o.int_b = 1'h0;
      next_o.int_cnt = 16'(INT_PULSE_CYC - 1);
    end else if (o.int_cnt != 16'h0000) begin
      next_o.int_cnt = o.int_cnt - 16'h0001;
    end else begin
      next_o.int_b = 1'h1;
    end
    if (o.blink_cnt == 27'(BLINK_HALF_CYC - 1)) begin
      next_o.blink_cnt = 27'h0;
      next_o.blink = ~o.blink;
    end else begin
      next_o.blink_cnt = o.blink_cnt + 27'h1;
    end
    // Suspend wins over the charging level
    next_o.stat_oe = o.sus_s2 ? o.blink : o.chg_s2;
  end

  always_ff @(posedge osc_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      o <= '{int_b: 1'h1, default: '0};
    end else begin
      o <= next_o;
    end
  end

  // Outputs straight from state flops
  assign scl_out = c.zero_drv;
  assign scl_oe_out = c.zero_drv;
  assign sda_out = c.zero_drv;
  assign sda_oe_out = c.sda_oe;
  assign stat_out = o.stat_lo;
  assign stat_oe_out = o.stat_oe;
  assign host_int_b_out = o.int_b;
  assign stop_converter_out = c.stop_conv;
  assign charge_enable_out = c.chg_en;
  assign current_limit_100ma_out = c.ilim100;
  assign thermal_reduce_out = c.therm_reduce;
  assign termination_disable_out = c.term_dis;
  assign timer_half_rate_out = c.half_rate;
  assign battery_path_switch_off_out = c.battery_path_switch_off;
  assign en_hiz_out = c.cfg[`CHS_IDX_SRC][`CHS_HIZ_BIT];
  assign host_mode_out = c.host_mode;

  // Address phase ending on our address
  sequence s_addr_hit;
    scl_fall && !start_det && !stop_det && c.st == chs_pkg::ST_ADDR && c.cnt == 4'h8 &&
      c.sh[7:1] == `CHS_I2C_ADDR;
  endsequence
  sequence s_bad_ptr;
    scl_fall && !start_det && !stop_det && c.st == chs_pkg::ST_RX && c.cnt == 4'h8 &&
      !c.got_ptr && c.sh > `CHS_REG_ID;
  endsequence
  addr_ack_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_addr_hit |=> c.st == chs_pkg::ST_ACK && sda_oe_out)
    else $error("own address not acknowledged");
  bad_ptr_nack_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_bad_ptr |=> c.st == chs_pkg::ST_WAIT && !sda_oe_out)
    else $error("undefined register not refused");
  fault_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !fault_rd |=> (c.fl & $past(c.fl)) == $past(c.fl))
    else $error("latched fault lost before read");
  fault_reload_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fault_rd |=> c.fl == $past(live))
    else $error("fault read did not reload live status");
  fault_lock_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    c.lock && !src_identified_in && !good_source_in && !input_removed_in &&
      !(charge_phase_in == `CHS_PH_DONE && c.phase_prev != `CHS_PH_DONE) |=> $stable(c.int_tog))
    else $error("interrupt raised while fault lock held");
  write_host_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_any |=> host_mode_out ##1 fault_byte[7] == 1'h0)
    else $error("write did not enter host mode");
  wd_self_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    c.cfg[`CHS_IDX_PWR][`CHS_WDRST_BIT] |=> !c.cfg[`CHS_IDX_PWR][`CHS_WDRST_BIT])
    else $error("watchdog restart bit stuck");
  path_latch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    system_overcurrent_in || battery_path_switch_off_out && (!supply_present_in || c.supply_prev)
      |=> battery_path_switch_off_out)
    else $error("path switch latch released early");
  conv_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    thermal_shutdown_in || input_overvoltage_fault_in || system_rail_overvoltage_in
      |=> stop_converter_out)
    else $error("converter not stopped on fault");
  int_pulse_a: assert property (@(posedge osc_clk_in) disable iff (!rst_b_in)
    (o.int_s2 ^ o.int_s3) |=> !host_int_b_out && o.int_cnt == 16'(INT_PULSE_CYC - 1))
    else $error("interrupt pulse not started");
  int_low_a: assert property (@(posedge osc_clk_in) disable iff (!rst_b_in)
    o.int_cnt != 16'h0000 |-> !host_int_b_out)
    else $error("interrupt pulse ended early");
  stat_level_a: assert property (@(posedge osc_clk_in) disable iff (!rst_b_in)
    !o.sus_s2 |=> stat_oe_out == $past(o.chg_s2))
    else $error("status pin does not follow charging");
endmodule

// *** tb/chs_host_model.sv ***
// Behavioural I2C master standing in for the host controller
`timescale 1ns/1ns
module chs_host_model #(
  parameter int QTR_NS = 40
) (
  // Open-drain pulls, high pulls the line low
  output logic scl_lo_out,
  output logic sda_lo_out,
  // Resolved line levels
  input wire logic scl_in,
  input wire logic sda_in
);
  // Both lines released at time zero, so the pull-ups hold the bus idle high
  initial begin
    scl_lo_out = 1'b0;
    sda_lo_out = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_lo_out = 1'b0;
    #QTR_NS scl_lo_out = 1'b0;
    #QTR_NS sda_lo_out = 1'b1;
    #QTR_NS scl_lo_out = 1'b1;
    #QTR_NS;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_lo_out = 1'b1;
    #QTR_NS scl_lo_out = 1'b0;
    #QTR_NS sda_lo_out = 1'b0;
    #QTR_NS;
  endtask
  // One byte MSB first, then the ninth bit; data moves only a quarter after SCL falls
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                      output logic r9);
    logic [8:0] w;
    w = {d, b9};
    for (int i = 8; i >= 0; i--) begin
      sda_lo_out = !w[i];
      #QTR_NS scl_lo_out = 1'b0;
      #QTR_NS w[i] = sda_in;
      #QTR_NS scl_lo_out = 1'b1;
      #QTR_NS;
    end
    q = w[8:1];
    r9 = w[0];
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the charger host status interface
`timescale 1ns/1ns
`include "chs_params.svh"
module tb;
  logic clk_in, osc_clk_in, rst_b_in, scl_oe, sda_oe, stat_oe, int_b, m_scl, m_sda, a;
  logic [17:0] ev;
  logic [8:0] o;
  logic [7:0] q;
  int num_errors = 0;
  int n_checks = 0;
  int n_int = 0;
  int w;
  // Open-drain lines with pull-ups
  wire scl = !(m_scl | scl_oe);
  wire sda = !(m_sda | sda_oe);
  // Short counts keep the run brief
  chs_top #(.INT_PULSE_CYC(8), .BLINK_HALF_CYC(16), .WD_TICK_CYC(5000), .WD_BASE_S(1)) u_chs_top (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .osc_clk_in(osc_clk_in), .scl_in(scl), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .stat_out(),
    .stat_oe_out(stat_oe), .host_int_b_out(int_b), .charge_phase_in(ev[14:13]),
    .charge_suspend_in(ev[12]), .src_identified_in(ev[0]), .good_source_in(ev[1]),
    .input_removed_in(ev[2]), .thermal_reg_in(ev[3]), .thermal_shutdown_in(ev[4]),
    .input_overvoltage_fault_in(ev[5]), .system_rail_overvoltage_in(ev[6]),
    .battery_overvoltage_fault_in(ev[7]), .safety_timer_fault_in(ev[8]),
    .ntc_fault_in(ev[17:15]), .battery_low_in(ev[9]), .system_overcurrent_in(ev[10]),
    .supply_present_in(ev[11]), .stop_converter_out(o[0]), .charge_enable_out(o[1]),
    .current_limit_100ma_out(o[2]), .thermal_reduce_out(o[3]), .termination_disable_out(o[4]),
    .timer_half_rate_out(o[5]), .battery_path_switch_off_out(o[6]), .en_hiz_out(o[7]),
    .host_mode_out(o[8]));
  chs_host_model u_chs_host_model (
    .scl_lo_out(m_scl), .sda_lo_out(m_sda), .scl_in(scl), .sda_in(sda));
  // Core clock, 4 ns
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = !clk_in;
  end
  // Oscillator, 6 ns; rising edges land on odd times, never on a core clock edge
  initial begin
    osc_clk_in = 1'b0;
    #2;
    forever #3 osc_clk_in = !osc_clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Count interrupt pulses; each must be low eight oscillator cycles
  always @(negedge int_b) begin
    n_int++;
    w = 0;
    while (int_b === 1'b0 && w < 100) begin
      @(posedge osc_clk_in);
      #1;
      w++;
    end
    chk(w[7:0], 8'h08);
  end
  // One-cycle event, then room for the pulse to finish
  task automatic pulse(input int i);
    @(negedge clk_in);
    ev[i] = 1'b1;
    @(negedge clk_in);
    ev[i] = 1'b0;
    repeat (40) @(negedge clk_in);
  endtask
  task automatic ack(input logic [7:0] d, input logic e);
    u_chs_host_model.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_chs_host_model.start();
    ack(8'hD6, 1'b0);
    ack(p, 1'b0);
    ack(d, 1'b0);
    u_chs_host_model.stop();
  endtask
  // Pointer write, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    u_chs_host_model.start();
    ack(8'hD6, 1'b0);
    ack(p, 1'b0);
    u_chs_host_model.start();
    ack(8'hD7, 1'b0);
    u_chs_host_model.xfer(8'hFF, 1'b1, q, a);
    u_chs_host_model.stop();
    chk(q, e);
  endtask
  task automatic t_reset();
    logic [7:0] dflt [8];
    dflt = '{`CHS_RST_REG0, `CHS_RST_REG1, `CHS_RST_REG2, `CHS_RST_REG3,
             `CHS_RST_REG4, `CHS_RST_REG5, `CHS_RST_REG6, `CHS_RST_REG7};
    chk({6'h00, o[8], o[1]}, 8'h01);
    u_chs_host_model.start();
    ack(8'hD7, 1'b0);
    for (int i = 0; i < 8; i++) begin
      u_chs_host_model.xfer(8'hFF, i == 7, q, a);
      chk(q, dflt[i]);
    end
    u_chs_host_model.stop();
    chk({7'h00, o[8]}, 8'h00);
  endtask
  task automatic t_mode();
    rd(8'h09, 8'h00);
    chk({7'h00, o[8]}, 8'h01);
    for (int k = 0; k < 20000 && o[8] !== 1'b0; k++) @(negedge clk_in);
    chk({7'h00, o[8]}, 8'h00);
    rd(8'h09, 8'h80);
    wr(8'h05, 8'h8A);
    wr(8'h01, 8'h5B);
    rd(8'h01, 8'h1B);
    rd(8'h09, 8'h00);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h0A, `CHS_ID_VALUE);
    wr(8'h00, 8'hB0);
    chk({7'h00, o[7]}, 8'h01);
  endtask
  task automatic t_nack();
    u_chs_host_model.start();
    ack(8'hD4, 1'b1);
    u_chs_host_model.stop();
    u_chs_host_model.start();
    ack(8'hD6, 1'b0);
    ack(8'h0B, 1'b1);
    u_chs_host_model.stop();
  endtask
  task automatic t_int();
    for (int i = 0; i < 3; i++) pulse(i);
    chk(n_int[7:0], 8'h03);
    pulse(4);
    pulse(7);
    chk(n_int[7:0], 8'h04);
    rd(8'h09, 8'h20);
    rd(8'h09, 8'h00);
    pulse(5);
    chk(n_int[7:0], 8'h05);
    rd(8'h09, 8'h10);
  endtask
  task automatic t_stat();
    @(negedge clk_in);
    ev[14:13] = 2'h1;
    repeat (20) @(negedge clk_in);
    chk({7'h00, stat_oe}, 8'h01);
    ev[3] = 1'b1;
    rd(8'h08, 8'h12);
    chk({5'h00, o[5:3]}, 8'h07);
    ev[12] = 1'b1;
    repeat (4) @(posedge osc_clk_in);
    #1;
    a = stat_oe;
    repeat (16) @(posedge osc_clk_in);
    #1;
    chk({7'h00, stat_oe}, {7'h00, !a});
    @(negedge clk_in);
    ev[12] = 1'b0;
    ev[3] = 1'b0;
    ev[14:13] = 2'h3;
    repeat (40) @(negedge clk_in);
    chk({7'h00, stat_oe}, 8'h00);
    chk(n_int[7:0], 8'h06);
  endtask
  // Protection levels, then the path switch latch against supply insertion
  task automatic t_prot();
    @(negedge clk_in);
    ev[10:6] = 5'h1B;
    repeat (3) @(negedge clk_in);
    chk({5'h00, o[6], o[2], o[0]}, 8'h07);
    chk({7'h00, o[1]}, 8'h00);
    ev = '0;
    repeat (3) @(negedge clk_in);
    chk({7'h00, o[6]}, 8'h01);
    ev[11] = 1'b1;
    repeat (3) @(negedge clk_in);
    chk({7'h00, o[6]}, 8'h00);
  endtask
  // Main sequence
  initial begin
    ev = '0;
    rst_b_in = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (5) @(negedge clk_in);
    t_reset();
    wr(8'h00, 8'h30);
    t_mode();
    t_nack();
    t_int();
    t_stat();
    t_prot();
    report_and_stop();
  end
  // Hang guard, well past the expected run of about 120 us
  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end
endmodule
